/* logic/ccr_pkg.sv */
// Constants and types for the clock conditioner register bank
package ccr_pkg;
  localparam int          WORD_W          = 32;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 28;
  localparam int          CNT_W           = 6;
  localparam logic [5:0]  WORD_BITS       = 6'h20;
  // Register addresses
  localparam logic [3:0]  ADDR_SOFT_RESET = 4'h0;
  localparam logic [3:0]  ADDR_OUT0       = 4'h4;
  localparam logic [3:0]  ADDR_OUT1       = 4'h5;
  localparam logic [3:0]  ADDR_OUT2       = 4'h6;
  localparam logic [3:0]  ADDR_OUT3       = 4'h7;
  localparam logic [3:0]  ADDR_LOCK_DIV   = 4'hB;
  localparam logic [3:0]  ADDR_GLOBAL     = 4'hE;
  localparam logic [3:0]  ADDR_GAIN_FB    = 4'hF;
  // Field positions in the 32-bit word
  localparam int          RESET_BIT       = 31;
  localparam int          MUX_HI          = 18;
  localparam int          MUX_LO          = 17;
  localparam int          EN_BIT          = 16;
  localparam int          DIV_HI          = 15;
  localparam int          DIV_LO          = 8;
  localparam int          DLY_HI          = 7;
  localparam int          DLY_LO          = 4;
  localparam int          QUARTER_BIT     = 15;
  localparam int          ALL_EN_BIT      = 27;
  localparam int          SLEEP_BIT       = 26;
  localparam int          HIZ_BIT         = 25;
  localparam int          POL_BIT         = 24;
  localparam int          LOCK_HI         = 23;
  localparam int          LOCK_LO         = 20;
  localparam int          RDIV_HI         = 19;
  localparam int          RDIV_LO         = 8;
  localparam int          GAIN_HI         = 31;
  localparam int          GAIN_LO         = 30;
  localparam int          NDIV_HI         = 25;
  localparam int          NDIV_LO         = 8;
  // Power-on defaults
  localparam logic [1:0]  MUX_RST         = 2'h0;
  localparam logic        EN_RST          = 1'b0;
  localparam logic [7:0]  DIV_RST         = 8'h01;
  localparam logic [3:0]  DLY_RST         = 4'h0;
  localparam logic        QUARTER_RST     = 1'b0;
  localparam logic        ALL_EN_RST      = 1'b1;
  localparam logic        SLEEP_RST       = 1'b0;
  localparam logic        HIZ_RST         = 1'b0;
  localparam logic        POL_RST         = 1'b0;
  localparam logic [3:0]  LOCK_RST        = 4'h0;
  localparam logic [11:0] RDIV_RST        = 12'h00A;
  localparam logic [1:0]  GAIN_RST        = 2'h0;
  localparam logic [17:0] NDIV_RST        = 18'h002F8;
  // Output path select codes
  localparam logic [1:0]  PATH_BYPASS     = 2'h0;
  localparam logic [1:0]  PATH_DIVIDED    = 2'h1;
  localparam logic [1:0]  PATH_DELAYED    = 2'h2;
  localparam logic [1:0]  PATH_BOTH       = 2'h3;
  // Added path delay in ps per select code
  localparam logic [9:0]  ADD_DLY_DIV     = 10'h064;
  localparam logic [9:0]  ADD_DLY_DLY     = 10'h190;
  localparam logic [9:0]  ADD_DLY_BOTH    = 10'h1F4;

  typedef struct packed {
    logic [1:0] output_path_select;
    logic       output_enable_bit;
    logic [7:0] output_divider_code;
    logic [3:0] output_delay_code;
  } ccr_out_cfg_s;

  typedef struct packed {
    logic        all_outputs_enable;
    logic        device_sleep;
    logic        pump_high_impedance;
    logic        pump_polarity;
    logic [3:0]  lock_status_pin;
    logic [11:0] ref_divider;
  } ccr_global_s;

  typedef struct packed {
    logic [1:0]  pump_current_gain;
    logic [17:0] feedback_divider;
  } ccr_gain_s;

  typedef struct packed {
    logic [2:0]        clk_sync;
    logic [2:0]        le_sync;
    logic [1:0]        data_sync;
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0]  count;
    ccr_out_cfg_s [3:0] outputs;
    logic              lock_detect_quarter;
    ccr_global_s       global_cfg;
    ccr_gain_s         gain_cfg;
    logic [3:0]        active;
    logic [3:0][9:0]   added_delay;
    logic              word_strobe;
  } ccr_state_s;
endpackage : ccr_pkg

/* logic/ccr_clock_conditioner_regs.sv */
// Serial-loaded write-only register bank of the clock conditioner
//
// Function
// RULE1 - Word is 32 bits: low four bits address, upper 28 bits data.
// RULE2 - Shift MSB first on rising clock while latch low; rising latch stores word.
// RULE3 - Addresses four to seven configure outputs zero to three, same layout.
// RULE4 - Reset bit 31 of register zero restores all defaults and clears itself.
// RULE5 - With reset set, other register-zero bits are ignored; host rewrites them.
// RULE6 - Host keeps the soft-reset bit at zero unless resetting.
// RULE7 - Mux field 18:17 selects bypass, divided, delayed, or both.
// RULE8 - Enable bit 16, divider 15:8 default 1, delay 7:4 default 0.
// RULE9 - Non-bypass paths add 100, 400, or 500 ps delay.
// RULE10 - Lock-detect divide bit 15 of register eleven, default zero.
// RULE11 - Global output enable bit 27 of register fourteen, default one.
// RULE12 - Power-down bit 26 of register fourteen, default zero.
// RULE13 - Bit 25 of register fourteen puts charge pump in high impedance.
// RULE14 - Bit 24 of register fourteen selects pump polarity, default negative.
// RULE15 - Lock pin selector 23:20 default 0; reference divider 19:8 default 10.
// RULE16 - Register fifteen: pump gain 31:30 default 0; feedback divider 25:8 default 760.
// RULE17 - Host writes fixed map bits with exactly their constant values; the bench sends words with all bits free, such as 7FFFFFF0 to register zero.
`timescale 1ns/1ns
module ccr_clock_conditioner_regs (
  input  wire logic                  SYS_CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  SERIAL_CLOCK_IN,
  input  wire logic                  SERIAL_DATA_IN,
  input  wire logic                  SERIAL_LATCH_ENABLE,
  output ccr_pkg::ccr_out_cfg_s [3:0] OUTPUT_CFG,
  output logic [3:0]                 OUTPUT_ACTIVE,
  output logic [3:0][9:0]            OUTPUT_ADDED_DELAY_PS,
  output logic                       LOCK_DETECT_QUARTER,
  output ccr_pkg::ccr_global_s       GLOBAL_CFG,
  output ccr_pkg::ccr_gain_s         GAIN_CFG,
  output logic                       WORD_STROBE
);

  ccr_pkg::ccr_state_s state_reg;
  ccr_pkg::ccr_state_s state_next;
  logic                clk_rise;
  logic                le_rise;
  logic [3:0]          word_addr;
  logic [27:0]         word_data;
  logic [31:0]         full_word;

  // Fixed added path delay for one select code
  function automatic logic [9:0] path_delay(input logic [1:0] sel);
    logic [9:0] d;
    d = 10'h000;
    unique case (sel)
      ccr_pkg::PATH_BYPASS:  d = 10'h000;
      ccr_pkg::PATH_DIVIDED: d = ccr_pkg::ADD_DLY_DIV;
      ccr_pkg::PATH_DELAYED: d = ccr_pkg::ADD_DLY_DLY;
      ccr_pkg::PATH_BOTH:    d = ccr_pkg::ADD_DLY_BOTH;
    endcase
    return d;
  endfunction : path_delay

  // Power-on defaults of all configuration fields
  function automatic ccr_pkg::ccr_state_s cfg_defaults(input ccr_pkg::ccr_state_s s);
    ccr_pkg::ccr_state_s r;
    r = s;
    for (int i = 0; i < 4; i++) begin
      r.outputs[i].output_path_select  = ccr_pkg::MUX_RST;
      r.outputs[i].output_enable_bit   = ccr_pkg::EN_RST;
      r.outputs[i].output_divider_code = ccr_pkg::DIV_RST;
      r.outputs[i].output_delay_code   = ccr_pkg::DLY_RST;
    end
    r.lock_detect_quarter            = ccr_pkg::QUARTER_RST;
    r.global_cfg.all_outputs_enable  = ccr_pkg::ALL_EN_RST;
    r.global_cfg.device_sleep        = ccr_pkg::SLEEP_RST;
    r.global_cfg.pump_high_impedance = ccr_pkg::HIZ_RST;
    r.global_cfg.pump_polarity       = ccr_pkg::POL_RST;
    r.global_cfg.lock_status_pin     = ccr_pkg::LOCK_RST;
    r.global_cfg.ref_divider         = ccr_pkg::RDIV_RST;
    r.gain_cfg.pump_current_gain     = ccr_pkg::GAIN_RST;
    r.gain_cfg.feedback_divider      = ccr_pkg::NDIV_RST;
    return r;
  endfunction : cfg_defaults

  // Per-output effective enable and fixed path delay, kept in flip-flops
  function automatic ccr_pkg::ccr_state_s derive_outputs(input ccr_pkg::ccr_state_s s);
    ccr_pkg::ccr_state_s r;
    r = s;
    for (int i = 0; i < 4; i++) begin
      r.active[i]      = s.outputs[i].output_enable_bit
                         & s.global_cfg.all_outputs_enable
                         & ~s.global_cfg.device_sleep; // RULE11 RULE12
      r.added_delay[i] = path_delay(s.outputs[i].output_path_select); // RULE9
    end
    return r;
  endfunction : derive_outputs

  // Whole state after a system reset: idle link, defaults, no strobe
  function automatic ccr_pkg::ccr_state_s reset_state();
    ccr_pkg::ccr_state_s r;
    r         = '0;
    r.le_sync = 3'h7; // Latch idles high, so release is no edge
    r         = derive_outputs(cfg_defaults(r));
    return r;
  endfunction : reset_state

  // Edge detection on synchronised link lines
  assign clk_rise  = state_reg.clk_sync[1] & ~state_reg.clk_sync[2];
  assign le_rise   = state_reg.le_sync[1] & ~state_reg.le_sync[2];
  assign full_word = state_reg.shift;
  assign word_addr = full_word[ccr_pkg::ADDR_W-1:0];              // RULE1
  assign word_data = full_word[ccr_pkg::WORD_W-1:ccr_pkg::ADDR_W]; // RULE1

  // Shift, latch and decode
  always_comb begin
    state_next             = state_reg;
    state_next.word_strobe = 1'b0;
    state_next.clk_sync    = {state_reg.clk_sync[1:0], SERIAL_CLOCK_IN};
    state_next.le_sync     = {state_reg.le_sync[1:0], SERIAL_LATCH_ENABLE};
    state_next.data_sync   = {state_reg.data_sync[0], SERIAL_DATA_IN};
    if (!state_reg.le_sync[1] && clk_rise) begin
      state_next.shift = {state_reg.shift[ccr_pkg::WORD_W-2:0], state_reg.data_sync[1]}; // RULE2
      if (state_reg.count != ccr_pkg::WORD_BITS) begin
        state_next.count = state_reg.count + 6'h01;
      end
    end
    if (le_rise) begin
      state_next.count       = '0;
      state_next.word_strobe = 1'b1;
      unique case (word_addr) // RULE2
        ccr_pkg::ADDR_SOFT_RESET: begin
          if (full_word[ccr_pkg::RESET_BIT]) begin
            state_next = cfg_defaults(state_next); // RULE4 RULE5
          end
        end
        ccr_pkg::ADDR_OUT0, ccr_pkg::ADDR_OUT1, ccr_pkg::ADDR_OUT2, ccr_pkg::ADDR_OUT3: begin
          state_next.outputs[word_addr[1:0]].output_path_select  =
            full_word[ccr_pkg::MUX_HI:ccr_pkg::MUX_LO]; // RULE3 RULE7
          state_next.outputs[word_addr[1:0]].output_enable_bit   = full_word[ccr_pkg::EN_BIT]; // RULE8
          state_next.outputs[word_addr[1:0]].output_divider_code =
            full_word[ccr_pkg::DIV_HI:ccr_pkg::DIV_LO]; // RULE8
          state_next.outputs[word_addr[1:0]].output_delay_code   =
            full_word[ccr_pkg::DLY_HI:ccr_pkg::DLY_LO]; // RULE8
        end
        ccr_pkg::ADDR_LOCK_DIV: begin
          state_next.lock_detect_quarter = full_word[ccr_pkg::QUARTER_BIT]; // RULE10
        end
        ccr_pkg::ADDR_GLOBAL: begin
          state_next.global_cfg.all_outputs_enable  = full_word[ccr_pkg::ALL_EN_BIT]; // RULE11
          state_next.global_cfg.device_sleep        = full_word[ccr_pkg::SLEEP_BIT]; // RULE12
          state_next.global_cfg.pump_high_impedance = full_word[ccr_pkg::HIZ_BIT]; // RULE13
          state_next.global_cfg.pump_polarity       = full_word[ccr_pkg::POL_BIT]; // RULE14
          state_next.global_cfg.lock_status_pin     = full_word[ccr_pkg::LOCK_HI:ccr_pkg::LOCK_LO]; // RULE15
          state_next.global_cfg.ref_divider         = full_word[ccr_pkg::RDIV_HI:ccr_pkg::RDIV_LO]; // RULE15
        end
        ccr_pkg::ADDR_GAIN_FB: begin
          state_next.gain_cfg.pump_current_gain = full_word[ccr_pkg::GAIN_HI:ccr_pkg::GAIN_LO]; // RULE16
          state_next.gain_cfg.feedback_divider  = full_word[ccr_pkg::NDIV_HI:ccr_pkg::NDIV_LO]; // RULE16
        end
        default: begin
          state_next.word_strobe = 1'b1; // Unused addresses store nothing
        end
      endcase
    end
    state_next = derive_outputs(state_next); // Same edge as the fields
  end

  // State register with power-on defaults
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_reg <= reset_state();
    end else begin
      state_reg <= state_next;
    end
  end

  // All outputs straight from flip-flops
  assign OUTPUT_CFG            = state_reg.outputs;
  assign OUTPUT_ACTIVE         = state_reg.active;
  assign OUTPUT_ADDED_DELAY_PS = state_reg.added_delay;
  assign LOCK_DETECT_QUARTER   = state_reg.lock_detect_quarter;
  assign GLOBAL_CFG            = state_reg.global_cfg;
  assign GAIN_CFG              = state_reg.gain_cfg;
  assign WORD_STROBE           = state_reg.word_strobe;

endmodule : ccr_clock_conditioner_regs

/* sim/ccr_host_model.sv */
// Host model driving the serial load port of the register bank
`timescale 1ns/1ns
module ccr_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      sdata,
  output logic      sle
);
  // Idle: latch high, serial clock parked low
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    sle = 1'b1;
  end
  // One word MSB first, 160 ns serial clock, then latch rise
  task automatic send_word(input logic [31:0] w);
    sle = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 31; i >= 0; i--) begin
      sdata = w[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    sle = 1'b1;
    sdata = ~sdata; // Released line shows no stale bit
  endtask : send_word
endmodule : ccr_host_model

/* sim/ccr_clock_conditioner_regs_asserts.sv */
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module ccr_clock_conditioner_regs_asserts (
  input wire logic                        SYS_CLK,
  input wire logic                        SYS_RST,
  input wire logic                        SERIAL_CLOCK_IN,
  input wire logic                        SERIAL_DATA_IN,
  input wire logic                        SERIAL_LATCH_ENABLE,
  input wire ccr_pkg::ccr_out_cfg_s [3:0] OUTPUT_CFG,
  input wire logic [3:0]                  OUTPUT_ACTIVE,
  input wire logic [3:0][9:0]             OUTPUT_ADDED_DELAY_PS,
  input wire logic                        LOCK_DETECT_QUARTER,
  input wire ccr_pkg::ccr_global_s        GLOBAL_CFG,
  input wire ccr_pkg::ccr_gain_s          GAIN_CFG,
  input wire logic                        WORD_STROBE
);
  logic [3:0]      en_bits;
  logic [3:0][9:0] dly_exp;
  // Expected enables and fixed path delays per output
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      en_bits[i] = OUTPUT_CFG[i].output_enable_bit;
      case (OUTPUT_CFG[i].output_path_select)
        2'h1: dly_exp[i] = 10'h064;
        2'h2: dly_exp[i] = 10'h190;
        2'h3: dly_exp[i] = 10'h1F4;
        default: dly_exp[i] = 10'h000;
      endcase
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  strobe_follows_a: assert property ($rose(SERIAL_LATCH_ENABLE) |-> ##[1:8] WORD_STROBE)
    else $error("no strobe after latch rise");
  strobe_single_a: assert property (WORD_STROBE |=> !WORD_STROBE)
    else $error("strobe wider than one cycle");
  strobe_quiet_a: assert property (!SERIAL_LATCH_ENABLE [*8] |-> !WORD_STROBE)
    else $error("strobe while shifting");
  cfg_hold_a: assert property ($changed({OUTPUT_CFG, GLOBAL_CFG, GAIN_CFG, LOCK_DETECT_QUARTER})
    |-> WORD_STROBE || $past(WORD_STROBE)) else $error("config changed without a word");
  active_gate_a: assert property (OUTPUT_ACTIVE ==
    (en_bits & {4{GLOBAL_CFG.all_outputs_enable & ~GLOBAL_CFG.device_sleep}})) else $error("bad active");
  sleep_blocks_a: assert property (GLOBAL_CFG.device_sleep |-> OUTPUT_ACTIVE == 4'h0)
    else $error("output active while asleep");
  path_delay_a: assert property (OUTPUT_ADDED_DELAY_PS == dly_exp)
    else $error("wrong added path delay");
  reset_default_a: assert property ($fell(SYS_RST) |-> GLOBAL_CFG == 20'h8000A && GAIN_CFG == 20'h002F8
    && OUTPUT_CFG == {4{15'h0010}} && !LOCK_DETECT_QUARTER) else $error("defaults missing after reset");
  strobe_c: cover property (WORD_STROBE);
  sleep_c: cover property (GLOBAL_CFG.device_sleep);
  both_c: cover property (OUTPUT_CFG[2].output_path_select == 2'h3);
endmodule : ccr_clock_conditioner_regs_asserts

/* sim/ccr_clock_conditioner_regs_bench.sv */
// Self-checking bench for the clock conditioner register bank
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module ccr_clock_conditioner_regs_bench;
  logic                        SYS_CLK = 1'b0;
  logic                        SYS_RST = 1'b1;
  logic                        sclk, sdata, sle, strobe, quarter, e_q;
  ccr_pkg::ccr_out_cfg_s [3:0] out_cfg, e_out;
  ccr_pkg::ccr_global_s        glob, e_g;
  ccr_pkg::ccr_gain_s          gain, e_n;
  logic [3:0]                  act, e_act;
  logic [3:0][9:0]             dly, e_dly;
  int                          num_errors = 0;
  int                          check_count = 0;
  int                          cycles = 0;
  int                          add_ps [4] = '{0, 100, 400, 500};
  logic [31:0]                 lfsr = 32'h29E658F5;
  logic [31:0]                 sent_q [$];
  logic [31:0]                 dir [12] = '{32'h00030534, 32'h0005FFF5, 32'h000600A6, 32'h00010217, 32'h0082800B,
    32'h233FFF0E, 32'hC3FFFF0F, 32'h7FFFFFF0, 32'hFFFFFFF9, 32'h2C000A0E, 32'h28000A0E, 32'h8ABCDEF0};
  always #10 SYS_CLK = ~SYS_CLK;
  ccr_clock_conditioner_regs u_ccr_clock_conditioner_regs (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .SERIAL_CLOCK_IN(sclk), .SERIAL_DATA_IN(sdata), .SERIAL_LATCH_ENABLE(sle), .OUTPUT_CFG(out_cfg),
    .OUTPUT_ACTIVE(act), .OUTPUT_ADDED_DELAY_PS(dly), .LOCK_DETECT_QUARTER(quarter), .GLOBAL_CFG(glob),
    .GAIN_CFG(gain), .WORD_STROBE(strobe));
  ccr_host_model u_ccr_host_model (.clk(SYS_CLK), .sclk(sclk), .sdata(sdata), .sle(sle));
  // Step the random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Power-on defaults of the model
  task automatic model_defaults();
    for (int i = 0; i < 4; i++) e_out[i] = {2'h0, 1'b0, 8'h01, 4'h0};
    e_q = 1'b0;
    e_g = {1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 12'h00A};
    e_n = {2'h0, 18'h002F8};
  endtask : model_defaults
  // Apply one latched word to the model
  task automatic model_write(input logic [31:0] w);
    int a;
    a = w[3:0];
    if (a == 0 && w[31]) model_defaults();
    else if (a >= 4 && a <= 7) e_out[a - 4] = w[18:4];
    else if (a == 11) e_q = w[15];
    else if (a == 14) e_g = w[27:8];
    else if (a == 15) e_n = {w[31:30], w[25:8]};
  endtask : model_write
  // Compare every output except the strobe against the model
  task automatic check_all();
    for (int i = 0; i < 4; i++) begin
      e_act[i] = e_out[i].output_enable_bit & e_g.all_outputs_enable & ~e_g.device_sleep;
      e_dly[i] = 10'(add_ps[e_out[i].output_path_select]);
    end
    `CHK("out_cfg", e_out, out_cfg)
    `CHK("active", e_act, act)
    `CHK("added_delay", e_dly, dly)
    `CHK("quarter", e_q, quarter)
    `CHK("global", e_g, glob)
    `CHK("gain", e_n, gain)
  endtask : check_all
  // Send a word, await its strobe, then compare
  task automatic write_word(input logic [31:0] w);
    int n;
    n = 0;
    sent_q.push_back(w);
    u_ccr_host_model.send_word(w);
    while (strobe !== 1'b1 && n < 20) begin
      @(negedge SYS_CLK);
      n++;
    end
    `CHK("strobe", 1'b1, strobe)
    repeat (2) @(negedge SYS_CLK);
    model_write(sent_q.pop_front());
    check_all();
  endtask : write_word
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // Cycle ceiling against a hang
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end
  // Reset, directed words, then random words
  initial begin
    model_defaults();
    repeat (6) @(negedge SYS_CLK);
    SYS_RST = 1'b0;
    @(negedge SYS_CLK);
    check_all();
    foreach (dir[k]) write_word(dir[k]);
    for (int k = 0; k < 24; k++) begin
      lfsr = lfsr_next(lfsr);
      write_word(lfsr[3:0] == 4'h0 ? {1'b0, lfsr[30:0]} : lfsr);
    end
    test_done();
  end
endmodule : ccr_clock_conditioner_regs_bench
bind ccr_clock_conditioner_regs ccr_clock_conditioner_regs_asserts u_ccr_clock_conditioner_regs_asserts (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN), .SERIAL_DATA_IN(SERIAL_DATA_IN),
  .SERIAL_LATCH_ENABLE(SERIAL_LATCH_ENABLE), .OUTPUT_CFG(OUTPUT_CFG), .OUTPUT_ACTIVE(OUTPUT_ACTIVE),
  .OUTPUT_ADDED_DELAY_PS(OUTPUT_ADDED_DELAY_PS), .LOCK_DETECT_QUARTER(LOCK_DETECT_QUARTER),
  .GLOBAL_CFG(GLOBAL_CFG), .GAIN_CFG(GAIN_CFG), .WORD_STROBE(WORD_STROBE));
